/* src/dps_consts.svh */
// Offsets, field positions and reset values of the sticky/repeat block
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DPS_CTRL_OFS  8'h00
`define DPS_CLR_OFS   8'h04
`define DPS_ID_OFS    8'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPS_WATCH_BIT 0
`define DPS_OVF_BIT   1
`define DPS_KIND_LO   2
`define DPS_MATCH_BIT 4
`define DPS_FAULT_BIT 5
`define DPS_PAR_BIT   7
`define DPS_MASK_LO   8
`define DPS_CNT_LO    12
`define DPS_CLR_MATCH 0
`define DPS_CLR_FAULT 1
`define DPS_CLR_PAR   2
`define DPS_CLR_OVF   3
`define DPS_ID_SCAN   0
`define DPS_ID_MIN    16
// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define DPS_RESP_OKAY 2'h0
`define DPS_RESP_SLV  2'h2
`define DPS_ALL_LANES 4'hF
`endif

/* src/dps_pkg.sv */
// Types shared by the sticky/repeat block
package dps_pkg;
    // Link request lines, sampled at the link clock rising edge
    typedef struct packed {
        logic valid;
        logic write;
        logic proto_ok;
        logic parity_ok;
    } dps_link_req_t;
    // Acknowledge codes returned to the probe
    typedef enum logic [1:0] {
        RESP_OK    = 2'h0,
        RESP_WAIT  = 2'h1,
        RESP_FAULT = 2'h2
    } dps_resp_t;
    // Register select
    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_CTRL = 2'h1,
        SEL_CLR  = 2'h2,
        SEL_ID   = 2'h3
    } dps_sel_t;
    // Access sequencer states
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } dps_state_t;
endpackage

/* src/dps_sticky_repeat.sv */
// Sticky error flags, overrun watch and access repeat engine
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.svh"

module dps_sticky_repeat #(
    parameter bit MINIMAL    = 1'b0,
    parameter bit SCAN_CHAIN = 1'b0,
    parameter int CNT_W      = 12
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    // Probe link
    input  wire logic                    link_clk,
    input  wire dps_pkg::dps_link_req_t  link_req,
    output logic                         link_resp_valid,
    output var dps_pkg::dps_resp_t       link_resp_code,
    // Access port side
    output logic                         ap_req,
    output logic                         ap_write,
    input  wire logic                    ap_done,
    input  wire logic                    ap_err,
    input  wire logic                    ap_match,
    // AXI4-Lite write channels
    input  wire logic [7:0]              s_awaddr,
    input  wire logic                    s_awvalid,
    output logic                         s_awready,
    input  wire logic [31:0]             s_wdata,
    input  wire logic [3:0]              s_wstrb,
    input  wire logic                    s_wvalid,
    output logic                         s_wready,
    output logic [1:0]                   s_bresp,
    output logic                         s_bvalid,
    input  wire logic                    s_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]              s_araddr,
    input  wire logic                    s_arvalid,
    output logic                         s_arready,
    output logic [31:0]                  s_rdata,
    output logic [1:0]                   s_rresp,
    output logic                         s_rvalid,
    input  wire logic                    s_rready
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic                   awready_reg, wready_reg, bvalid_reg, arready_reg;
    logic [1:0]             bresp_reg, rresp_reg, kind_reg;
    logic [31:0]            rdata_reg, rdata_next, wdata_reg;
    logic [7:0]             awaddr_reg;
    logic [3:0]             wstrb_reg, mask_reg;
    logic                   wr_fire, full_wr, ap_req_reg, ap_write_reg;
    dps_pkg::dps_sel_t      wsel, rsel;
    logic [CNT_W-1:0]       cnt_reg;
    logic                   fault_reg, ovf_reg, par_reg, match_reg;
    logic                   clr_fault, clr_ovf, clr_par, clr_match;
    logic                   fault_set, ovf_set, par_set, match_set;
    logic                   lclk_s1, lclk_s2, lclk_s3;
    dps_pkg::dps_link_req_t req_s1, req_s2;
    logic                   link_edge, txn, speak, err_pend, fwd, rvalid_reg;
    dps_pkg::dps_resp_t     resp_next, resp_code_reg;
    dps_pkg::dps_state_t    state_reg;
    logic                   busy, stop_rep, again, watch_reg, resp_valid_reg;

    // Register address decode, shared by both bus directions
    function automatic dps_pkg::dps_sel_t reg_sel(input logic [7:0] a);
        if (a == `DPS_CTRL_OFS) begin
            reg_sel = dps_pkg::SEL_CTRL;
        end else if (a == `DPS_CLR_OFS) begin
            reg_sel = dps_pkg::SEL_CLR;
        end else if (a == `DPS_ID_OFS) begin
            reg_sel = dps_pkg::SEL_ID;
        end else begin
            reg_sel = dps_pkg::SEL_NONE;
        end
    endfunction

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    // Address and data are taken in either order, answer follows both
    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    assign wsel    = reg_sel(awaddr_reg);
    assign full_wr = wr_fire && (wstrb_reg == `DPS_ALL_LANES);

    // Write address capture
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            awready_reg <= 1'b1;
            awaddr_reg  <= 8'h00;
        end else if (s_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            awaddr_reg  <= s_awaddr;
        end else if (bvalid_reg && s_bready) begin
            awready_reg <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wready_reg <= 1'b1;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (s_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            wdata_reg  <= s_wdata;
            wstrb_reg  <= s_wstrb;
        end else if (bvalid_reg && s_bready) begin
            wready_reg <= 1'b1;
        end
    end

    // Write response, unmapped address answers SLVERR
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `DPS_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wsel == dps_pkg::SEL_NONE) ? `DPS_RESP_SLV
                                                      : `DPS_RESP_OKAY;
        end else if (bvalid_reg && s_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    assign rsel = reg_sel(s_araddr);

    // Read word assembly; minimal variant keeps four fields at zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (rsel == dps_pkg::SEL_CTRL) begin
            rdata_next[`DPS_WATCH_BIT]          = watch_reg;
            rdata_next[`DPS_OVF_BIT]            = ovf_reg;
            rdata_next[`DPS_KIND_LO+:2]         = kind_reg;
            rdata_next[`DPS_MATCH_BIT]          = match_reg;
            rdata_next[`DPS_FAULT_BIT]          = fault_reg;
            rdata_next[`DPS_PAR_BIT]            = par_reg;
            rdata_next[`DPS_MASK_LO+:4]         = mask_reg;
            rdata_next[`DPS_CNT_LO+:CNT_W]      = cnt_reg;
        end else if (rsel == dps_pkg::SEL_ID) begin
            rdata_next[`DPS_ID_MIN]  = MINIMAL;
            rdata_next[`DPS_ID_SCAN] = SCAN_CHAIN;
        end
    end

    // Read handshake and data register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= `DPS_RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
        end else if (s_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rdata_next;
            rresp_reg   <= (rsel == dps_pkg::SEL_NONE) ? `DPS_RESP_SLV
                                                       : `DPS_RESP_OKAY;
        end else if (rvalid_reg && s_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    // Watch enable, transfer kind and lane mask; kind and mask kept zero when minimal
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            watch_reg <= 1'b0;
            kind_reg  <= 2'h0;
            mask_reg  <= 4'h0;
        end else if (full_wr && wsel == dps_pkg::SEL_CTRL) begin
            watch_reg <= wdata_reg[`DPS_WATCH_BIT];
            kind_reg  <= MINIMAL ? 2'h0 : wdata_reg[`DPS_KIND_LO+:2];
            mask_reg  <= MINIMAL ? 4'h0 : wdata_reg[`DPS_MASK_LO+:4];
        end
    end

    // Clear strobes; match clear is ignored in the minimal variant
    assign clr_fault = full_wr && wsel == dps_pkg::SEL_CLR
                       && wdata_reg[`DPS_CLR_FAULT];
    assign clr_ovf   = full_wr && wsel == dps_pkg::SEL_CLR
                       && wdata_reg[`DPS_CLR_OVF];
    assign clr_par   = full_wr && wsel == dps_pkg::SEL_CLR
                       && wdata_reg[`DPS_CLR_PAR];
    assign clr_match = full_wr && wsel == dps_pkg::SEL_CLR
                       && wdata_reg[`DPS_CLR_MATCH] && !MINIMAL;

    // ----------------------------------------
    // Link sampling
    // ----------------------------------------
    // Two-stage synchronisers, edge found from the second stage on
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
            req_s1  <= '0;
            req_s2  <= '0;
        end else begin
            lclk_s1 <= link_clk;
            lclk_s2 <= lclk_s1;
            lclk_s3 <= lclk_s2;
            req_s1  <= link_req;
            req_s2  <= req_s1;
        end
    end

    assign link_edge = lclk_s2 && !lclk_s3;
    assign txn       = link_edge && req_s2.valid;
    assign busy      = (state_reg == dps_pkg::ST_BUSY);
    assign err_pend  = fault_reg | ovf_reg | par_reg | match_reg;

    // ----------------------------------------
    // Transaction triage
    // ----------------------------------------
    // Chooses the acknowledge and whether the access is forwarded
    always_comb begin
        speak     = txn && req_s2.proto_ok;
        resp_next = dps_pkg::RESP_OK;
        fwd       = 1'b0;
        par_set   = 1'b0;
        if (busy && (SCAN_CHAIN || !err_pend)) begin
            resp_next = dps_pkg::RESP_WAIT;
        end else if (err_pend) begin
            resp_next = SCAN_CHAIN ? dps_pkg::RESP_OK
                                   : dps_pkg::RESP_FAULT;
        end else if (req_s2.write && !req_s2.parity_ok) begin
            par_set = speak;
        end else begin
            fwd = speak;
        end
        ovf_set = speak && watch_reg
                  && (SCAN_CHAIN ? resp_next == dps_pkg::RESP_WAIT
                                 : resp_next != dps_pkg::RESP_OK);
    end

    // Acknowledge out; protocol errors stay silent
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resp_valid_reg <= 1'b0;
            resp_code_reg  <= dps_pkg::RESP_OK;
        end else begin
            resp_valid_reg <= speak;
            resp_code_reg  <= resp_next;
        end
    end

    // ----------------------------------------
    // Access sequencer with repeat count
    // ----------------------------------------
    assign fault_set = busy && ap_done && ap_err;
    assign match_set = busy && ap_done && ap_match && !MINIMAL;
    assign stop_rep  = (cnt_reg == '0) || ap_err || fault_reg
                       || match_reg || match_set;
    assign again     = busy && ap_done && !stop_rep;

    // Idle/busy state and access strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= dps_pkg::ST_IDLE;
            ap_req_reg   <= 1'b0;
            ap_write_reg <= 1'b0;
        end else begin
            ap_req_reg <= 1'b0;
            case (state_reg)
                dps_pkg::ST_IDLE: begin
                    if (fwd) begin
                        state_reg    <= dps_pkg::ST_BUSY;
                        ap_req_reg   <= 1'b1;
                        ap_write_reg <= req_s2.write;
                    end
                end
                default: begin
                    if (again) begin
                        ap_req_reg <= 1'b1;
                    end else if (ap_done) begin
                        state_reg <= dps_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Repeat count: decrement after each good access with count left, loaded only by a full CTRL write
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
        end else if (MINIMAL) begin
            cnt_reg <= '0;
        end else if (full_wr && wsel == dps_pkg::SEL_CTRL) begin
            cnt_reg <= wdata_reg[`DPS_CNT_LO+:CNT_W];
        end else if (again) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // ----------------------------------------
    // Sticky flags, set wins over clear
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault_reg <= 1'b0;
            ovf_reg   <= 1'b0;
            par_reg   <= 1'b0;
            match_reg <= 1'b0;
        end else begin
            fault_reg <= fault_set | (fault_reg & ~clr_fault);
            ovf_reg   <= ovf_set | (ovf_reg & ~clr_ovf);
            par_reg   <= par_set | (par_reg & ~clr_par);
            match_reg <= match_set | (match_reg & ~clr_match);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_awready       = awready_reg;
    assign s_wready        = wready_reg;
    assign s_bvalid        = bvalid_reg;
    assign s_bresp         = bresp_reg;
    assign s_arready       = arready_reg;
    assign s_rvalid        = rvalid_reg;
    assign s_rresp         = rresp_reg;
    assign s_rdata         = rdata_reg;
    assign link_resp_valid = resp_valid_reg;
    assign link_resp_code  = resp_code_reg;
    assign ap_req          = ap_req_reg;
    assign ap_write        = ap_write_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking dps_cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Fault flag holds until cleared
    a_fault_holds: assert property (
        fault_reg && !clr_fault |=> fault_reg
    ) else $error("fault flag dropped without clear");
    // Access error reaches the fault flag
    a_fault_sets: assert property (
        busy && ap_done && ap_err |=> fault_reg
    ) else $error("access error did not set fault flag");
    // Overflow only rises in watch mode
    a_ovf_watch: assert property (
        !watch_reg && !ovf_reg |=> !ovf_reg
    ) else $error("overflow set outside watch mode");
    // Overrun leaves fault flag untouched
    a_ovf_no_fault: assert property (
        ovf_set && !fault_set && !clr_fault |=> $stable(fault_reg)
    ) else $error("overrun changed fault flag");
    // Protocol error yields no acknowledge
    a_proto_silent: assert property (
        txn && !req_s2.proto_ok |=> !link_resp_valid
    ) else $error("acknowledge sent for bad request");
    // Pending error blocks forwarding
    a_err_discard: assert property (
        txn && err_pend && !busy |=> !ap_req ##1 !ap_req
    ) else $error("access forwarded while error pending");
    // Scan port waits while busy
    a_scan_wait: assert property (
        SCAN_CHAIN && speak && busy |=>
            link_resp_code == dps_pkg::RESP_WAIT
    ) else $error("scan port did not answer WAIT");

    // Serial port faults while overflow set
    a_serial_fault: assert property (
        !SCAN_CHAIN && speak && ovf_reg |=>
            link_resp_valid && link_resp_code == dps_pkg::RESP_FAULT
    ) else $error("serial port did not answer FAULT");

    // Good access with count left repeats and decrements
    a_cnt_dec: assert property (
        again && !(full_wr && wsel == dps_pkg::SEL_CTRL) |=>
            ap_req && cnt_reg == $past(cnt_reg) - 1'b1
    ) else $error("repeat did not decrement count");

    // Fault cuts repeats and keeps the count
    a_cnt_keep: assert property (
        fault_set && !full_wr |=> $stable(cnt_reg) && !ap_req
    ) else $error("count changed on faulted access");

    // Minimal variant has no count
    a_min_zero: assert property (
        MINIMAL |-> cnt_reg == '0 && !match_reg
    ) else $error("minimal variant count or match nonzero");

endmodule
`default_nettype wire

/* sim/dps_probe_model.sv */
// Probe model that paces the link clock and request lines
`timescale 1ns/1ps
`default_nettype none
module dps_probe_model (
    // Pacing clock
    input  wire logic              clock,
    // Link toward the block
    output logic                   link_clk,
    output dps_pkg::dps_link_req_t link_req
);
    // Link clock stands still between frames
    initial begin
        link_clk = 1'b0;
        link_req = '0;
    end

    // One frame of 600 ns: setup, rise, hold, then release
    task automatic send(input logic w, input logic p, input logic par);
        @(posedge clock);
        link_req <= '{1'b1, w, p, par};
        repeat (4) @(posedge clock);
        link_clk <= 1'b1;
        repeat (4) @(posedge clock);
        link_clk <= 1'b0;
        link_req <= '{1'b0, ~w, ~p, ~par}; // Released lines show no stale value
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* sim/dps_testbench.sv */
// Self-checking bench for the sticky flag and repeat block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                   clock, reset_n, link_clk, ap_req, ap_write;
    logic                   ap_done, ap_err, ap_match, link_resp_valid;
    dps_pkg::dps_link_req_t link_req;
    dps_pkg::dps_resp_t     link_resp_code, code_seen;
    logic [7:0]             awaddr, araddr;
    logic [31:0]            wdata, rdata;
    logic [3:0]             wstrb;
    logic [1:0]             bresp, rresp;
    logic                   awvalid, awready, wvalid, wready, bvalid, bready;
    logic                   arvalid, arready, rvalid, rready;
    int                     n_fail, checks_done, n_resp, n_ap, pend;
    int                     ap_lat, cycles;
    logic                   use2, v2, ap_req2, ap_wr2, dir_seen;
    logic [31:0]            rdata2;
    dps_pkg::dps_resp_t     code2;

    dps_sticky_repeat dut_u (.clock(clock), .reset_n(reset_n),
        .link_clk(link_clk), .link_req(link_req),
        .link_resp_valid(link_resp_valid), .link_resp_code(link_resp_code),
        .ap_req(ap_req), .ap_write(ap_write), .ap_done(ap_done),
        .ap_err(ap_err), .ap_match(ap_match), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready));
    dps_probe_model probe_u (.clock(clock), .link_clk(link_clk),
        .link_req(link_req));
    // Scan-chain minimal variant on the same stimulus
    dps_sticky_repeat #(.MINIMAL(1'b1), .SCAN_CHAIN(1'b1)) dut2_u (
        .clock(clock), .reset_n(reset_n), .link_clk(link_clk),
        .link_req(link_req), .link_resp_valid(v2), .link_resp_code(code2),
        .ap_req(ap_req2), .ap_write(ap_wr2), .ap_done(ap_done),
        .ap_err(ap_err), .ap_match(ap_match), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(), .s_wdata(wdata),
        .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(),
        .s_bresp(), .s_bvalid(), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(),
        .s_rdata(rdata2), .s_rresp(), .s_rvalid(),
        .s_rready(rready));

    // Clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Access port responder, answer monitor and hang limit
    always @(posedge clock) begin
        cycles <= cycles + 1;
        ap_done <= 1'b0;
        if ((use2 ? v2 : link_resp_valid) === 1'b1) begin
            n_resp <= n_resp + 1;
            code_seen <= use2 ? code2 : link_resp_code;
        end
        if ((use2 ? ap_req2 : ap_req) === 1'b1) begin
            n_ap <= n_ap + 1;
            pend <= ap_lat;
            dir_seen <= use2 ? ap_wr2 : ap_write;
        end else if (pend > 0) begin
            pend <= pend - 1;
            ap_done <= (pend == 1);
        end
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ad = 0;
        bit wd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clock);
            if (awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'h0, bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", e, use2 ? rdata2 : rdata);
        chk("rresp", er, rresp);
    endtask
    task automatic lnk(input logic w, input logic p, input logic par,
                       input logic [31:0] ec, input int er, input int ea);
        int r0;
        int a0;
        r0 = n_resp;
        a0 = n_ap;
        probe_u.send(w, p, par);
        repeat (16) @(posedge clock);
        chk("answer count", er, n_resp - r0);
        chk("access count", ea, n_ap - a0);
        if (er > 0) chk("answer code", ec, code_seen);
        if (ea > 0) chk("access dir", w, dir_seen);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_repeat();
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h0C, 32'h0, 2'h2);
        wr(8'h00, 32'h0000_2F0C);
        lnk(1'b1, 1'b1, 1'b1, 32'h0, 1, 3);
        rd(8'h00, 32'h0000_0F0C, 2'h0);
    endtask
    task automatic t_fault();
        wr(8'h00, 32'h0000_3000);
        ap_err <= 1'b1;
        lnk(1'b0, 1'b1, 1'b1, 32'h0, 1, 1);
        ap_err <= 1'b0;
        rd(8'h00, 32'h0000_3020, 2'h0);
        lnk(1'b0, 1'b1, 1'b1, 32'h2, 1, 0);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h0);
        lnk(1'b0, 1'b1, 1'b1, 32'h0, 1, 1);
        wr(8'h00, 32'h0000_2000);
        ap_match <= 1'b1;
        lnk(1'b0, 1'b1, 1'b1, 32'h0, 1, 1);
        ap_match <= 1'b0;
        rd(8'h00, 32'h0000_2010, 2'h0);
        wr(8'h04, 32'h1);
    endtask
    task automatic t_overrun();
        ap_lat = 100;
        wr(8'h00, 32'h1);
        lnk(1'b0, 1'b1, 1'b1, 32'h0, 1, 1);
        lnk(1'b0, 1'b1, 1'b1, 32'h1, 1, 0);
        lnk(1'b0, 1'b1, 1'b1, 32'h2, 1, 0);
        rd(8'h00, 32'h3, 2'h0);
        repeat (100) @(posedge clock);
        rd(8'h00, 32'h3, 2'h0);
        wr(8'h04, 32'h8);
        rd(8'h00, 32'h1, 2'h0);
        wr(8'h00, 32'h0);
        ap_lat = 2;
    endtask
    task automatic t_parity();
        lnk(1'b1, 1'b1, 1'b0, 32'h0, 1, 0);
        rd(8'h00, 32'h80, 2'h0);
        wr(8'h04, 32'h4);
        lnk(1'b0, 1'b0, 1'b1, 32'h0, 0, 0);
        rd(8'h00, 32'h0, 2'h0);
    endtask
    task automatic t_scan();
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        use2 <= 1'b1;
        repeat (4) @(posedge clock);
        rd(8'h08, 32'h0001_0001, 2'h0);
        wr(8'h00, 32'h0000_2F0D);
        rd(8'h00, 32'h1, 2'h0);
        ap_lat = 100;
        lnk(1'b0, 1'b1, 1'b1, 32'h0, 1, 1);
        lnk(1'b0, 1'b1, 1'b1, 32'h1, 1, 0);
        rd(8'h00, 32'h3, 2'h0);
        repeat (100) @(posedge clock);
        ap_lat = 2;
        lnk(1'b0, 1'b1, 1'b1, 32'h0, 1, 0);
        wr(8'h04, 32'h8);
        wr(8'h00, 32'h0);
        ap_match <= 1'b1;
        lnk(1'b0, 1'b1, 1'b1, 32'h0, 1, 1);
        ap_match <= 1'b0;
        rd(8'h00, 32'h0, 2'h0);
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        {ap_done, ap_err, ap_match, awvalid, wvalid, bready, use2} = '0;
        {arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {n_fail, checks_done, n_resp, n_ap, pend, cycles} = '0;
        ap_lat = 2;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_repeat();
        t_fault();
        t_overrun();
        t_parity();
        t_scan();
        final_report();
    end
endmodule
`default_nettype wire
